// ==== hdl/wdr_top.sv ====
// Watchdog reset timer: APB registers, guarded writes, 8-bit counter, overflow reset
//
// The register addresses and the APB interface to the registers were left to the implementer.
module wdr_top (
	// Clock and external reset pin
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Oscillator and low-power hint
	input wire logic osc_clk_in,
	input wire logic low_power_mode,
	// Internal reset to the chip
	output logic sys_reset_out
);

	// ----------------------------------------
	// Control state and counter
	// ----------------------------------------
	wdr_pkg::wdr_ctrl_t ctl_q, ctl_d;  // Enables, run, flag, clock select
	logic [7:0] cnt_q, cnt_d;         // wdt_counter
	logic [31:0] rdata_q, rdata_d;    // Registered read data
	logic err_q, err_d;               // Registered slave error
	logic tick;                       // One-cycle count pulse
	logic osc_tick;                   // One-cycle oscillator edge
	logic eff_tick;                   // Tick gated by operating mode
	logic wrap;                       // Counter wraps this cycle
	logic wr, rd, hit;
	logic [7:0] wb;
	logic cnt_wr;                     // Counter write that the enable lets through

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	wdr_tick_sel u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.cks(ctl_q.cks),
		.osc_clk_in(osc_clk_in),
		.tick(tick),
		.osc_tick(osc_tick)
	);

	wdr_rst_gen u_rst (
		.clk(clk),
		.reset_n(reset_n),
		.trigger(wrap),
		.osc_tick(osc_tick),
		.sys_reset_out(sys_reset_out)
	);

	// Decodes a mapped address; used by the error path only
	function automatic logic mapped(input logic [11:0] a);
		return (a == wdr_pkg::ADDR_CTRL) || (a == wdr_pkg::ADDR_CNT) ||
			(a == wdr_pkg::ADDR_CKS);
	endfunction

	// Builds the control/status read value with guard bits forced to one
	function automatic logic [7:0] ctrl_view(input wdr_pkg::wdr_ctrl_t c);
		logic [7:0] v;
		v = 8'h00;
		v[wdr_pkg::B_CNT_GUARD] = 1'b1;
		v[wdr_pkg::B_CTL_GUARD] = 1'b1;
		v[wdr_pkg::B_RUN_GUARD] = 1'b1;
		v[wdr_pkg::B_FLG_GUARD] = 1'b1;
		v[wdr_pkg::B_CNT_WE] = c.cnt_we;
		v[wdr_pkg::B_CTL_WE] = c.ctl_we;
		v[wdr_pkg::B_RUN] = c.run;
		v[wdr_pkg::B_FLG] = c.flag;
		return v;
	endfunction

	// ----------------------------------------
	// Bus decode; one wait-free access phase
	// ----------------------------------------
	// Writes act only at the access edge, so one transfer changes state once
	always_comb begin
		wr = psel & penable & pwrite;
		rd = psel & penable & ~pwrite;
		hit = mapped(paddr);
		wb = pwdata[7:0];
		cnt_wr = wr & (paddr == wdr_pkg::ADDR_CNT) & ctl_q.cnt_we;
		pready = 1'b1;
	end

	// Divided sources stop in low-power modes; the oscillator does not
	always_comb begin
		eff_tick = tick & (~low_power_mode | ~ctl_q.cks[3]);
	end

	// ----------------------------------------
	// Counter and control next state
	// ----------------------------------------
	// Software writes do not race the wrap: the flag set beats its own clear
	always_comb begin
		ctl_d = ctl_q;
		cnt_d = cnt_q;
		wrap = 1'b0;
		// Counting only while running; wrap FF to 00
		if (ctl_q.run && eff_tick) begin
			cnt_d = cnt_q + 8'h01;
			wrap = (cnt_q == wdr_pkg::CNT_MAX);
		end
		if (wr && paddr == wdr_pkg::ADDR_CTRL) begin
			if (!wb[wdr_pkg::B_CNT_GUARD]) begin
				ctl_d.cnt_we = wb[wdr_pkg::B_CNT_WE];
			end
			if (!wb[wdr_pkg::B_CTL_GUARD]) begin
				ctl_d.ctl_we = wb[wdr_pkg::B_CTL_WE];
			end
			// Run and flag use the enable as it stood before this write
			if (ctl_q.ctl_we && !wb[wdr_pkg::B_RUN_GUARD]) begin
				ctl_d.run = wb[wdr_pkg::B_RUN];
			end
			if (ctl_q.ctl_we && !wb[wdr_pkg::B_FLG_GUARD] && !wb[wdr_pkg::B_FLG]) begin
				ctl_d.flag = 1'b0;
			end
		end
		if (cnt_wr) begin
			cnt_d = wb;
		end
		if (wr && paddr == wdr_pkg::ADDR_CKS) begin
			ctl_d.cks = wb[3:0];
		end
		if (wrap) begin
			ctl_d.flag = 1'b1;
		end
	end

	// Registers only; external pin resets everything
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q <= '{cnt_we: 1'b0, ctl_we: 1'b0, run: 1'b0, flag: 1'b0,
				cks: wdr_pkg::CKS_RESET};
			cnt_q <= wdr_pkg::CNT_RESET;
		end else begin
			ctl_q <= ctl_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// Read data and error
	// ----------------------------------------
	// Read data settle in the setup cycle so they stand at the access edge
	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		if (psel && !penable) begin
			err_d = ~hit;
			case (paddr)
				wdr_pkg::ADDR_CTRL: begin
					rdata_d = {24'h00_0000, ctrl_view(ctl_q)};
				end
				wdr_pkg::ADDR_CNT: begin
					rdata_d = {24'h00_0000, cnt_q};
				end
				wdr_pkg::ADDR_CKS: begin
					rdata_d = {24'h00_0000, wdr_pkg::CKS_RSVD_ONES, ctl_q.cks};
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end else if (psel) begin
			rdata_d = rdata_q;
			err_d = err_q;
		end
	end

	// Registers only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	assign prdata = rdata_q;
	assign pslverr = err_q & psel & penable;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Every check sleeps while the pin reset is low
	// A set guard bit freezes the enable that it protects
	sequence s_guarded_we_write;
		wr && paddr == wdr_pkg::ADDR_CTRL && pwdata[wdr_pkg::B_CTL_GUARD];
	endsequence

	chk_ctl_we_guard: assert property (@(posedge clk) disable iff (!reset_n)
		s_guarded_we_write |=> $stable(ctl_q.ctl_we))
		else $error("control enable changed with guard set");

	chk_cnt_we_guard: assert property (@(posedge clk) disable iff (!reset_n)
		wr && paddr == wdr_pkg::ADDR_CTRL && pwdata[wdr_pkg::B_CNT_GUARD]
		|=> $stable(ctl_q.cnt_we))
		else $error("counter enable changed with guard set");

	// A locked counter ignores software writes
	chk_cnt_write_lock: assert property (@(posedge clk) disable iff (!reset_n)
		wr && paddr == wdr_pkg::ADDR_CNT && !ctl_q.cnt_we && !(ctl_q.run && eff_tick)
		|=> $stable(cnt_q))
		else $error("locked counter accepted a write");

	chk_cnt_write_take: assert property (@(posedge clk) disable iff (!reset_n)
		wr && paddr == wdr_pkg::ADDR_CNT && ctl_q.cnt_we |=> cnt_q == $past(pwdata[7:0]))
		else $error("counter write not taken");

	// Run holds unless an enabled control write arrives
	chk_run_lock: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr && paddr == wdr_pkg::ADDR_CTRL && ctl_q.ctl_we) |=> $stable(ctl_q.run))
		else $error("run bit changed while locked");

	chk_run_guard: assert property (@(posedge clk) disable iff (!reset_n)
		wr && paddr == wdr_pkg::ADDR_CTRL && pwdata[wdr_pkg::B_RUN_GUARD] |=> $stable(ctl_q.run))
		else $error("run bit changed with guard set");

	// A halted counter moves only by software
	chk_halt_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!ctl_q.run && !wr |=> $stable(cnt_q))
		else $error("counter moved while halted");

	// A wrap raises the reset and the flag; the counter lands on zero unless a write wins
	chk_wrap_reset: assert property (@(posedge clk) disable iff (!reset_n)
		ctl_q.run && eff_tick && cnt_q == wdr_pkg::CNT_MAX
		|=> ctl_q.flag && sys_reset_out
		&& cnt_q == ($past(cnt_wr) ? $past(pwdata[7:0]) : 8'h00))
		else $error("wrap did not reset and flag");

	// Flag survives anything but an enabled control write
	chk_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
		ctl_q.flag && !(wr && paddr == wdr_pkg::ADDR_CTRL && ctl_q.ctl_we) |=> ctl_q.flag)
		else $error("flag cleared without guarded write");

	chk_guard_read: assert property (@(posedge clk) disable iff (!reset_n)
		rd && paddr == wdr_pkg::ADDR_CTRL |-> (prdata[7:0] & 8'hAA) == 8'hAA)
		else $error("guard bit read as zero");

	// Counter moves by exactly one per accepted tick when no write competes
	sequence s_plain_step;
		ctl_q.run && eff_tick && !cnt_wr;
	endsequence

	chk_count_step: assert property (@(posedge clk) disable iff (!reset_n)
		s_plain_step |=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("counter did not advance by one");

	// An enabled write with the run guard at zero lands on the next edge
	chk_run_take: assert property (@(posedge clk) disable iff (!reset_n)
		wr && paddr == wdr_pkg::ADDR_CTRL && ctl_q.ctl_we && !pwdata[wdr_pkg::B_RUN_GUARD]
		|=> ctl_q.run == $past(pwdata[wdr_pkg::B_RUN]))
		else $error("run write not taken");

	// A guarded zero clears the flag unless a wrap sets it in the same cycle
	chk_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
		wr && paddr == wdr_pkg::ADDR_CTRL && ctl_q.ctl_we && !pwdata[wdr_pkg::B_FLG_GUARD]
		&& !pwdata[wdr_pkg::B_FLG] && !wrap |=> !ctl_q.flag)
		else $error("flag not cleared by guarded zero");

	// Divided sources stay frozen in low-power modes
	chk_low_power_stop: assert property (@(posedge clk) disable iff (!reset_n)
		low_power_mode && ctl_q.cks[3] && !cnt_wr |=> $stable(cnt_q))
		else $error("divided source counted in low-power mode");

	// The oscillator source keeps counting in low-power modes
	chk_osc_keeps: assert property (@(posedge clk) disable iff (!reset_n)
		low_power_mode && !ctl_q.cks[3] && ctl_q.run && tick && !cnt_wr
		|=> cnt_q != $past(cnt_q))
		else $error("oscillator source stopped in low-power mode");

	// The chip reset can only end on an oscillator edge
	chk_rst_needs_osc: assert property (@(posedge clk) disable iff (!reset_n)
		sys_reset_out && !osc_tick |=> sys_reset_out)
		else $error("internal reset ended without an oscillator edge");

endmodule

// ==== include/wdr_pkg.sv ====
// Package: register map, field layout and timing constants of the watchdog reset timer
package wdr_pkg;

	// ----------------------------------------
	// Register map (byte addresses on APB)
	// ----------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;  // wdt_control_status
	localparam logic [11:0] ADDR_CNT = 12'h004;   // wdt_counter
	localparam logic [11:0] ADDR_CKS = 12'h008;   // wdt_clock_select_register

	// ----------------------------------------
	// Control/status field positions
	// ----------------------------------------
	localparam int B_CNT_GUARD = 7;   // counter_we_guard
	localparam int B_CNT_WE = 6;      // counter_write_enable
	localparam int B_CTL_GUARD = 5;   // control_we_guard
	localparam int B_CTL_WE = 4;      // control_write_enable
	localparam int B_RUN_GUARD = 3;   // run_bit_guard
	localparam int B_RUN = 2;         // watchdog_run
	localparam int B_FLG_GUARD = 1;   // flag_bit_guard
	localparam int B_FLG = 0;         // overflow_reset_flag

	// ----------------------------------------
	// Reset values and widths
	// ----------------------------------------
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [3:0] CKS_RESET = 4'hF;
	localparam logic [3:0] CKS_RSVD_ONES = 4'hF;  // Upper bits of clock select read 1
	localparam int PRE_W = 13;                    // Prescaler width, reaches divide by 8192
	localparam int DIV_BASE_BIT = 5;              // Bit 5 toggles at divide by 64
	localparam int RST_OSC_CYCLES = 256;          // Internal reset length in oscillator cycles
	localparam int RST_CNT_W = 9;

	// Control state, grouped for the main file
	typedef struct packed {
		logic cnt_we;
		logic ctl_we;
		logic run;
		logic flag;
		logic [3:0] cks;
	} wdr_ctrl_t;

	// Internal reset sequencer states, one-hot
	typedef enum logic [1:0] {
		RS_IDLE = 2'b01,
		RS_HOLD = 2'b10
	} wdr_rst_state_t;

endpackage

// ==== hdl/wdr_tick_sel.sv ====
// Count tick source: prescaler, clock select and edge detection to one-cycle ticks
module wdr_tick_sel (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Clock select and oscillator
	input wire logic [3:0] cks,
	input wire logic osc_clk_in,
	// Result
	output logic tick,
	output logic osc_tick
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [wdr_pkg::PRE_W-1:0] pre_q, pre_d;  // Free-running prescaler
	logic sel_q, sel_d;                        // Selected source level, last cycle
	logic osc_q, osc_d;                        // Oscillator level, last cycle
	logic sel_now;

	// Picks the prescaler bit or oscillator; top bit 0 means oscillator
	function automatic logic pick(input logic [3:0] c, input logic [wdr_pkg::PRE_W-1:0] p,
		input logic o);
		logic r;
		r = o;
		if (c[3]) begin
			r = p[wdr_pkg::DIV_BASE_BIT + int'(c[2:0])];
		end
		return r;
	endfunction

	// Next state and rising-edge ticks; a source switch from low to high may count once
	always_comb begin
		pre_d = pre_q + {{(wdr_pkg::PRE_W-1){1'b0}}, 1'b1};
		sel_now = pick(cks, pre_q, osc_clk_in);
		sel_d = sel_now;
		osc_d = osc_clk_in;
		tick = sel_now & ~sel_q;
		osc_tick = osc_clk_in & ~osc_q;
	end

	// Registers only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q <= '0;
			sel_q <= 1'b0;
			osc_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			sel_q <= sel_d;
			osc_q <= osc_d;
		end
	end

endmodule

// ==== hdl/wdr_rst_gen.sv ====
// Internal reset stretcher: holds the chip reset for a fixed count of oscillator cycles
module wdr_rst_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Trigger and timebase
	input wire logic trigger,
	input wire logic osc_tick,
	// Result
	output logic sys_reset_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	wdr_pkg::wdr_rst_state_t st_q, st_d;
	logic [wdr_pkg::RST_CNT_W-1:0] cnt_q, cnt_d;  // Oscillator cycles elapsed

	// Next state: start on trigger, count oscillator edges to the full length
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			wdr_pkg::RS_IDLE: begin
				if (trigger) begin
					st_d = wdr_pkg::RS_HOLD;
					cnt_d = '0;
				end
			end
			wdr_pkg::RS_HOLD: begin
				// A wrap inside the pulse restarts the full length, so no overflow is lost
				if (trigger) begin
					cnt_d = '0;
				end else if (osc_tick) begin
					cnt_d = cnt_q + 9'h001;
					if (cnt_q == 9'(wdr_pkg::RST_OSC_CYCLES - 1)) begin
						st_d = wdr_pkg::RS_IDLE;
					end
				end
			end
			default: begin
				st_d = wdr_pkg::RS_IDLE;
			end
		endcase
	end

	// Registers only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= wdr_pkg::RS_IDLE;
			cnt_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	assign sys_reset_out = (st_q == wdr_pkg::RS_HOLD);

	// Reset may only end after the full count of oscillator edges
	chk_rst_len_full: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(sys_reset_out) |-> $past(cnt_q) == 9'(wdr_pkg::RST_OSC_CYCLES - 1))
		else $error("internal reset ended early");

endmodule

// ==== sim/wdr_tb.sv ====
// Testbench for the watchdog reset timer: APB access, guarded writes, sources, overflow reset
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus, observation and bookkeeping
	// ----------------------------------------
	logic clk;
	logic reset_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic osc_clk_in = 1'b0;
	logic low_power_mode;
	logic sys_reset_out;
	logic [1:0] osc_div_q = 2'h0;  // Oscillator runs at a quarter of clk
	logic osc_prev_q = 1'b0;
	logic [7:0] rd;
	logic err;
	int errors;
	int checks;
	int cycles = 0;
	int osc_edges = 0;  // Oscillator rises seen while the chip reset is out

	wdr_top wdr_top_inst (
		.clk(clk),
		.reset_n(reset_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.osc_clk_in(osc_clk_in),
		.low_power_mode(low_power_mode),
		.sys_reset_out(sys_reset_out)
	);

	// Clock of 5 ns
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Oscillator and reset-length counting; an edge is judged as the design samples it
	always @(posedge clk) begin
		osc_div_q <= osc_div_q + 2'h1;
		osc_clk_in <= osc_div_q[1];
		osc_prev_q <= osc_clk_in;
		if (sys_reset_out === 1'b1 && osc_clk_in === 1'b1 && osc_prev_q === 1'b0) begin
			osc_edges++;
		end
	end

	// Hang guard, sized above the longest divider sweep
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			errors++;
			$display("Error at %0t: timeout", $time);
			test_done();
		end
	end

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic test_done;
		if (errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Range compare; an unknown lands in the else branch
	task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		checks++;
		if (got >= lo && got <= hi) begin
		end else begin
			errors++;
			$display("Error at %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb_xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		apb_xfer(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] a;
		int div;
		int n;
		int base;  // Oscillator edge tally when the overflow run starts
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		low_power_mode = 1'b0;
		errors = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		// Reset values, then an unmapped place
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hAA);
		rd_chk(wdr_pkg::ADDR_CNT, 8'h00);
		rd_chk(wdr_pkg::ADDR_CKS, 8'hFF);
		apb_xfer(1'b0, 12'h00C, 8'h00);
		chk({7'h00, err}, 8'h01);
		// Counter locked until its enable is set with the guard at 0
		wr(wdr_pkg::ADDR_CNT, 8'h33);
		rd_chk(wdr_pkg::ADDR_CNT, 8'h00);
		wr(wdr_pkg::ADDR_CTRL, 8'hC0);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hAA);
		wr(wdr_pkg::ADDR_CTRL, 8'h6A);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hEA);
		wr(wdr_pkg::ADDR_CNT, 8'h5A);
		rd_chk(wdr_pkg::ADDR_CNT, 8'h5A);
		// Run refused while control writes are locked; counter stays put
		wr(wdr_pkg::ADDR_CTRL, 8'hF7);
		repeat (100) @(posedge clk);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hEA);
		rd_chk(wdr_pkg::ADDR_CNT, 8'h5A);
		wr(wdr_pkg::ADDR_CTRL, 8'hDF);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hFA);
		wr(wdr_pkg::ADDR_CTRL, 8'hFF);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hFA);
		// Every source: four periods give three to five counts
		for (int c = 0; c < 9; c++) begin
			a = (c < 8) ? (8'h08 + c[7:0]) : 8'h07;
			div = (c < 8) ? (64 << c) : 4;
			wr(wdr_pkg::ADDR_CTRL, 8'hF3);
			wr(wdr_pkg::ADDR_CNT, 8'h00);
			wr(wdr_pkg::ADDR_CKS, a);
			rd_chk(wdr_pkg::ADDR_CKS, 8'hF0 | a);
			wr(wdr_pkg::ADDR_CTRL, 8'hF7);
			repeat (4 * div) @(posedge clk);
			apb_xfer(1'b0, wdr_pkg::ADDR_CNT, 8'h00);
			chk_rng({8'h00, rd}, 16'h0003, 16'h0005);
		end
		// Halt freezes the count
		wr(wdr_pkg::ADDR_CTRL, 8'hF3);
		apb_xfer(1'b0, wdr_pkg::ADDR_CNT, 8'h00);
		a = rd;
		repeat (64) @(posedge clk);
		rd_chk(wdr_pkg::ADDR_CNT, a);
		// Low-power mode: divided source stops, oscillator keeps counting
		wr(wdr_pkg::ADDR_CNT, 8'h00);
		wr(wdr_pkg::ADDR_CKS, 8'h08);
		low_power_mode <= 1'b1;
		wr(wdr_pkg::ADDR_CTRL, 8'hF7);
		repeat (256) @(posedge clk);
		rd_chk(wdr_pkg::ADDR_CNT, 8'h00);
		wr(wdr_pkg::ADDR_CKS, 8'h00);
		repeat (40) @(posedge clk);
		apb_xfer(1'b0, wdr_pkg::ADDR_CNT, 8'h00);
		chk_rng({8'h00, rd}, 16'h0008, 16'h000D);
		low_power_mode <= 1'b0;
		// Overflow from a written start three counts below the wrap
		wr(wdr_pkg::ADDR_CTRL, 8'hF3);
		wr(wdr_pkg::ADDR_CNT, 8'hFD);
		base = osc_edges;
		wr(wdr_pkg::ADDR_CTRL, 8'hF7);
		n = 0;
		while (sys_reset_out !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk_rng(n[15:0], 16'h0002, 16'h0014);
		// Halt so that no second wrap lands inside the pulse
		wr(wdr_pkg::ADDR_CTRL, 8'hF3);
		n = 0;
		while (sys_reset_out !== 1'b0 && n < 1200) begin
			@(posedge clk);
			n++;
		end
		n = osc_edges - base;
		chk_rng(n[15:0], 16'h00FF, 16'h0101);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hFB);
		wr(wdr_pkg::ADDR_CTRL, 8'hFA);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hFB);
		wr(wdr_pkg::ADDR_CTRL, 8'hF8);
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hFA);
		// Pin reset in mid-run clears run, enables and counter
		wr(wdr_pkg::ADDR_CTRL, 8'hF7);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(wdr_pkg::ADDR_CTRL, 8'hAA);
		rd_chk(wdr_pkg::ADDR_CNT, 8'h00);
		test_done();
	end
endmodule
